// file: msa_pkg.sv
package msa_pkg;

    // Register map
    localparam logic [3:0] MSA_OFS_AXIS_SETUP  = 4'h2;
    localparam logic [3:0] MSA_OFS_LIMIT_SETUP = 4'h3;
    localparam logic [3:0] MSA_OFS_X_LIMIT     = 4'h4;
    localparam logic [3:0] MSA_OFS_Y_LIMIT     = 4'h5;
    localparam logic [3:0] MSA_OFS_Z_LIMIT     = 4'h6;
    localparam logic [7:0] MSA_RESET_VALUE     = 8'h00;
    localparam logic [7:0] MSA_LIMIT_SETUP_MASK = 8'h7F;

    // Field positions
    localparam int MSA_CH_SEL_LO   = 4;
    localparam int MSA_IDLE_LO     = 0;
    localparam int MSA_CROSS_BIT   = 6;
    localparam int MSA_DIR_BIT     = 5;
    localparam int MSA_GAIN_BIT    = 4;
    localparam int MSA_ANGLE_LO    = 2;
    localparam int MSA_XY_SPAN_BIT = 1;
    localparam int MSA_Z_SPAN_BIT  = 0;

    // Encodings
    localparam logic [1:0] MSA_PWR_WAKE_SLEEP = 2'h3;
    localparam logic [2:0] MSA_STYLE_SIGNED   = 3'h0;
    localparam logic [2:0] MSA_STYLE_HYST     = 3'h1;
    localparam logic [2:0] MSA_CROSS_ONE      = 3'h1;
    localparam logic [2:0] MSA_CROSS_FOUR     = 3'h4;
    localparam logic [1:0] MSA_ANGLE_OFF      = 2'h0;
    localparam logic [1:0] MSA_ANGLE_XY       = 2'h1;
    localparam logic [1:0] MSA_ANGLE_YZ       = 2'h2;

    // Timing
    localparam int MSA_CLK_PERIOD_NS = 10;
    localparam int MSA_MS_TIME_NS    = 1000000;
    localparam int MSA_MS_CYCLES_DEF = MSA_MS_TIME_NS / MSA_CLK_PERIOD_NS;
    localparam logic [7:0] MSA_BASE_RANGE_DEF = 8'h28;

    typedef enum logic [1:0] {MSA_AX_NONE, MSA_AX_X, MSA_AX_Y, MSA_AX_Z} msa_axis_e;
    typedef enum logic [1:0] {MSA_WS_OFF, MSA_WS_IDLE, MSA_WS_CONVERT} msa_ws_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } msa_reg_req_s;

    typedef struct packed {
        logic [1:0] len;
        msa_axis_e  slot0;
        msa_axis_e  slot1;
        msa_axis_e  slot2;
    } msa_seq_s;

    typedef struct packed {
        logic      en;
        msa_axis_e first;
        msa_axis_e second;
        msa_axis_e gain_axis;
    } msa_angle_s;

    // Idle interval in milliseconds per code
    function automatic logic [14:0] msa_idle_ms(input logic [3:0] code);
        case (code)
            4'h0:    msa_idle_ms = 15'h0001;
            4'h1:    msa_idle_ms = 15'h0005;
            4'h2:    msa_idle_ms = 15'h000A;
            4'h3:    msa_idle_ms = 15'h000F;
            4'h4:    msa_idle_ms = 15'h0014;
            4'h5:    msa_idle_ms = 15'h001E;
            4'h6:    msa_idle_ms = 15'h0032;
            4'h7:    msa_idle_ms = 15'h0064;
            4'h8:    msa_idle_ms = 15'h01F4;
            4'h9:    msa_idle_ms = 15'h03E8;
            4'hA:    msa_idle_ms = 15'h07D0;
            4'hB:    msa_idle_ms = 15'h1388;
            default: msa_idle_ms = 15'h4E20;
        endcase
    endfunction

endpackage

// file: msa_limit_setup.sv
`timescale 1ns/1ps
// Behaviour
// - Codes 0-7 enable X/Y/Z channel combinations
// - Codes 8-11 run interleaved sequences; 12-15 reserved
// - Idle interval applies only in wake-sleep state
// - Crossing bit: event after one or four crossings
// - Direction bit: flag above or below threshold
// - Direction ignored when style above one
// - Gain bit picks first or second angle axis
// - Angle pair field: off, XY, YZ, XZ
// - Planar span bit doubles X/Y range
// - Vertical span bit doubles Z range
// - X limit is signed eight-bit code
// - Threshold equals base times span times code/128
// - Zero limit code disables that axis
// - Y limit scaled by planar span
// - Z limit scaled by vertical span
// - Power state three is wake-up and sleep
// - Style one uses seven-bit symmetric thresholds
module msa_limit_setup #(
    parameter int         MS_CYCLES  = msa_pkg::MSA_MS_CYCLES_DEF,
    parameter logic [7:0] BASE_RANGE = msa_pkg::MSA_BASE_RANGE_DEF
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port
    input  wire msa_pkg::msa_reg_req_s reg_req,
    output logic [7:0]                rdata,
    // Settings held in neighbouring registers
    input  wire logic [1:0]           power_state,
    input  wire logic [2:0]           limit_style,
    // Conversion engine
    input  wire logic                 conversion_done,
    output logic                      conversion_request,
    output logic [2:0]                axis_enable,
    output msa_pkg::msa_seq_s         axis_sequence,
    output msa_pkg::msa_angle_s       angle_setup,
    output logic                      xy_range_double,
    output logic                      z_range_double,
    // Limit check, levels in units of 1/128 mT
    input  wire logic                 sample_valid,
    input  wire logic [2:0][17:0]     field_sample,
    output logic [2:0][17:0]          limit_level,
    input  wire logic                 limit_event_clear,
    output logic                      limit_event
);
    import msa_pkg::*;

    logic [7:0]       axis_setup_reg;
    logic [7:0]       limit_setup_reg;
    logic [2:0][7:0]  limit_code_reg;
    logic [7:0]       rdata_reg;
    logic [2:0]       axis_en_reg;
    msa_seq_s         seq_reg;
    msa_angle_s       angle_reg;
    logic             xy_double_reg;
    logic             z_double_reg;
    logic [2:0][17:0] level_reg;
    logic             conv_req_reg;
    logic             event_reg;
    logic [1:0]       cross_cnt_reg;
    logic             beyond_prev_reg;
    msa_ws_e          ws_state_reg;
    logic [16:0]      tick_cnt_reg;
    logic [14:0]      ms_cnt_reg;
    logic [2:0]       beyond;
    logic             crossing;
    logic [2:0]       cross_needed;
    logic [3:0]       ch_code;
    logic [1:0]       angle_code;

    assign ch_code    = axis_setup_reg[MSA_CH_SEL_LO +: 4];
    assign angle_code = limit_setup_reg[MSA_ANGLE_LO +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge clk) begin
        if (rst) begin
            axis_setup_reg  <= MSA_RESET_VALUE;
            limit_setup_reg <= MSA_RESET_VALUE;
            limit_code_reg  <= '0;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                MSA_OFS_AXIS_SETUP:  axis_setup_reg <= reg_req.wdata;
                MSA_OFS_LIMIT_SETUP: limit_setup_reg <= reg_req.wdata & MSA_LIMIT_SETUP_MASK;
                MSA_OFS_X_LIMIT:     limit_code_reg[0] <= reg_req.wdata;
                MSA_OFS_Y_LIMIT:     limit_code_reg[1] <= reg_req.wdata;
                MSA_OFS_Z_LIMIT:     limit_code_reg[2] <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // Read data lands one cycle after the strobe; other offsets belong elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= MSA_RESET_VALUE;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                MSA_OFS_AXIS_SETUP:  rdata_reg <= axis_setup_reg;
                MSA_OFS_LIMIT_SETUP: rdata_reg <= limit_setup_reg & MSA_LIMIT_SETUP_MASK;
                MSA_OFS_X_LIMIT:     rdata_reg <= limit_code_reg[0];
                MSA_OFS_Y_LIMIT:     rdata_reg <= limit_code_reg[1];
                MSA_OFS_Z_LIMIT:     rdata_reg <= limit_code_reg[2];
                default:             rdata_reg <= MSA_RESET_VALUE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel selection

    always_ff @(posedge clk) begin
        if (rst) begin
            axis_en_reg <= '0;
            seq_reg     <= '{2'h0, MSA_AX_NONE, MSA_AX_NONE, MSA_AX_NONE};
        end else begin
            // Reserved codes fall to all-off so a stray value cannot start sampling
            case (ch_code)
                4'h1: begin axis_en_reg <= 3'h1; seq_reg <= '{2'h1, MSA_AX_X, MSA_AX_NONE, MSA_AX_NONE}; end
                4'h2: begin axis_en_reg <= 3'h2; seq_reg <= '{2'h1, MSA_AX_Y, MSA_AX_NONE, MSA_AX_NONE}; end
                4'h3: begin axis_en_reg <= 3'h3; seq_reg <= '{2'h2, MSA_AX_X, MSA_AX_Y, MSA_AX_NONE}; end
                4'h4: begin axis_en_reg <= 3'h4; seq_reg <= '{2'h1, MSA_AX_Z, MSA_AX_NONE, MSA_AX_NONE}; end
                4'h5: begin axis_en_reg <= 3'h5; seq_reg <= '{2'h2, MSA_AX_Z, MSA_AX_X, MSA_AX_NONE}; end
                4'h6: begin axis_en_reg <= 3'h6; seq_reg <= '{2'h2, MSA_AX_Y, MSA_AX_Z, MSA_AX_NONE}; end
                4'h7: begin axis_en_reg <= 3'h7; seq_reg <= '{2'h3, MSA_AX_X, MSA_AX_Y, MSA_AX_Z}; end
                4'h8: begin axis_en_reg <= 3'h3; seq_reg <= '{2'h3, MSA_AX_X, MSA_AX_Y, MSA_AX_X}; end
                4'h9: begin axis_en_reg <= 3'h3; seq_reg <= '{2'h3, MSA_AX_Y, MSA_AX_X, MSA_AX_Y}; end
                4'hA: begin axis_en_reg <= 3'h6; seq_reg <= '{2'h3, MSA_AX_Y, MSA_AX_Z, MSA_AX_Y}; end
                4'hB: begin axis_en_reg <= 3'h5; seq_reg <= '{2'h3, MSA_AX_X, MSA_AX_Z, MSA_AX_X}; end
                default: begin
                    axis_en_reg <= 3'h0;
                    seq_reg     <= '{2'h0, MSA_AX_NONE, MSA_AX_NONE, MSA_AX_NONE};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Angle pair, gain target and range

    always_ff @(posedge clk) begin
        if (rst) begin
            angle_reg     <= '{1'b0, MSA_AX_NONE, MSA_AX_NONE, MSA_AX_NONE};
            xy_double_reg <= 1'b0;
            z_double_reg  <= 1'b0;
        end else begin
            xy_double_reg <= limit_setup_reg[MSA_XY_SPAN_BIT];
            z_double_reg  <= limit_setup_reg[MSA_Z_SPAN_BIT];
            case (angle_code)
                MSA_ANGLE_OFF: angle_reg <= '{1'b0, MSA_AX_NONE, MSA_AX_NONE, MSA_AX_NONE};
                MSA_ANGLE_XY:  angle_reg <= '{1'b1, MSA_AX_X, MSA_AX_Y,
                                   limit_setup_reg[MSA_GAIN_BIT] ? MSA_AX_Y : MSA_AX_X};
                MSA_ANGLE_YZ:  angle_reg <= '{1'b1, MSA_AX_Y, MSA_AX_Z,
                                   limit_setup_reg[MSA_GAIN_BIT] ? MSA_AX_Z : MSA_AX_Y};
                default:       angle_reg <= '{1'b1, MSA_AX_X, MSA_AX_Z,
                                   limit_setup_reg[MSA_GAIN_BIT] ? MSA_AX_Z : MSA_AX_X};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-axis threshold levels and comparison

    for (genvar g = 0; g < 3; g++) begin : g_axis
        logic              span;
        logic signed [17:0] level;
        logic signed [17:0] mag;
        logic signed [17:0] field;

        // X and Y share the planar span, Z has its own
        assign span  = (g == 2) ? limit_setup_reg[MSA_Z_SPAN_BIT]
                                : limit_setup_reg[MSA_XY_SPAN_BIT];
        assign field = $signed(field_sample[g]);

        // Exact product kept in 1/128 mT so no rounding enters the compare
        always_comb begin
            level = 18'(signed'(limit_code_reg[g]) * signed'({1'b0, BASE_RANGE}));
            mag   = 18'(signed'({1'b0, limit_code_reg[g][6:0]}) * signed'({1'b0, BASE_RANGE}));
            if (span) begin
                level = level <<< 1;
                mag   = mag <<< 1;
            end
        end

        always_comb begin
            beyond[g] = 1'b0;
            if (limit_code_reg[g] != 8'h00) begin
                case (limit_style)
                    MSA_STYLE_SIGNED: beyond[g] = limit_setup_reg[MSA_DIR_BIT]
                                                  ? (field < level) : (field > level);
                    MSA_STYLE_HYST:   beyond[g] = limit_setup_reg[MSA_DIR_BIT]
                                                  ? (field < mag && field > -mag)
                                                  : (field > mag || field < -mag);
                    default:          beyond[g] = 1'b0;
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                level_reg[g] <= '0;
            end else begin
                level_reg[g] <= (limit_style == MSA_STYLE_HYST) ? mag : level;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing count and limit event

    assign crossing     = sample_valid && (|beyond) && !beyond_prev_reg;
    assign cross_needed = limit_setup_reg[MSA_CROSS_BIT] ? MSA_CROSS_FOUR : MSA_CROSS_ONE;

    always_ff @(posedge clk) begin
        if (rst) begin
            beyond_prev_reg <= 1'b0;
            cross_cnt_reg   <= '0;
            event_reg       <= 1'b0;
        end else begin
            if (sample_valid) begin
                beyond_prev_reg <= |beyond;
            end
            // A crossing in the clearing cycle still sets the event
            if (limit_event_clear) begin
                event_reg <= 1'b0;
            end
            if (crossing) begin
                if ({1'b0, cross_cnt_reg} + 3'h1 >= cross_needed) begin
                    event_reg     <= 1'b1;
                    cross_cnt_reg <= '0;
                end else begin
                    cross_cnt_reg <= cross_cnt_reg + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up and sleep idle timer

    always_ff @(posedge clk) begin
        if (rst) begin
            ws_state_reg <= MSA_WS_OFF;
            tick_cnt_reg <= '0;
            ms_cnt_reg   <= '0;
            conv_req_reg <= 1'b0;
        end else begin
            conv_req_reg <= 1'b0;
            case (ws_state_reg)
                MSA_WS_OFF: begin
                    tick_cnt_reg <= '0;
                    ms_cnt_reg   <= '0;
                    if (power_state == MSA_PWR_WAKE_SLEEP) begin
                        ws_state_reg <= MSA_WS_IDLE;
                    end
                end
                MSA_WS_IDLE: begin
                    if (power_state != MSA_PWR_WAKE_SLEEP) begin
                        ws_state_reg <= MSA_WS_OFF;
                    end else if (tick_cnt_reg == 17'(MS_CYCLES - 1)) begin
                        tick_cnt_reg <= '0;
                        if (ms_cnt_reg + 15'h1 >= msa_idle_ms(axis_setup_reg[MSA_IDLE_LO +: 4])) begin
                            ms_cnt_reg   <= '0;
                            conv_req_reg <= 1'b1;
                            ws_state_reg <= MSA_WS_CONVERT;
                        end else begin
                            ms_cnt_reg <= ms_cnt_reg + 15'h1;
                        end
                    end else begin
                        tick_cnt_reg <= tick_cnt_reg + 17'h1;
                    end
                end
                MSA_WS_CONVERT: begin
                    if (power_state != MSA_PWR_WAKE_SLEEP) begin
                        ws_state_reg <= MSA_WS_OFF;
                    end else if (conversion_done) begin
                        ws_state_reg <= MSA_WS_IDLE;
                    end
                end
                default: ws_state_reg <= MSA_WS_OFF;
            endcase
        end
    end

    assign rdata              = rdata_reg;
    assign conversion_request = conv_req_reg;
    assign axis_enable        = axis_en_reg;
    assign axis_sequence      = seq_reg;
    assign angle_setup        = angle_reg;
    assign xy_range_double    = xy_double_reg;
    assign z_range_double     = z_double_reg;
    assign limit_level        = level_reg;
    assign limit_event        = event_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_write_ch(logic [3:0] code);
        reg_req.wr && reg_req.addr == MSA_OFS_AXIS_SETUP && reg_req.wdata[7:4] == code;
    endsequence

    sequence s_axis_quiet;
        !(reg_req.wr && reg_req.addr == MSA_OFS_AXIS_SETUP);
    endsequence

    a_chsel_xy_pair: assert property (@(posedge clk) disable iff (rst)
        s_write_ch(4'h3) ##1 s_axis_quiet |=> axis_enable == 3'h3 && axis_sequence.len == 2'h2)
        else $error("channel code 3 did not enable X and Y");

    a_chsel_interleave: assert property (@(posedge clk) disable iff (rst)
        s_write_ch(4'hA) ##1 s_axis_quiet |=> axis_sequence.slot0 == MSA_AX_Y
            && axis_sequence.slot1 == MSA_AX_Z && axis_sequence.slot2 == MSA_AX_Y)
        else $error("channel code A did not give Y-Z-Y");

    a_idle_gated_mode: assert property (@(posedge clk) disable iff (rst)
        power_state != MSA_PWR_WAKE_SLEEP [*2] |=> !conversion_request)
        else $error("conversion requested outside wake-sleep");

    a_idle_quiet_gap: assert property (@(posedge clk) disable iff (rst)
        conversion_request |=> !conversion_request [*2])
        else $error("idle interval shorter than allowed");

    a_single_crossing: assert property (@(posedge clk) disable iff (rst)
        crossing && !limit_setup_reg[MSA_CROSS_BIT] |=> limit_event)
        else $error("single crossing did not raise event");

    a_four_crossing: assert property (@(posedge clk) disable iff (rst)
        crossing && limit_setup_reg[MSA_CROSS_BIT] && cross_cnt_reg == 2'h0 && !limit_event
            && !limit_event_clear |=> !limit_event)
        else $error("event raised before fourth crossing");

    a_zero_code_off: assert property (@(posedge clk) disable iff (rst)
        limit_code_reg[0] == 8'h00 && limit_code_reg[1] == 8'h00 && limit_code_reg[2] == 8'h00
            |-> !crossing)
        else $error("zero limit code still compared");

    a_style_reserved: assert property (@(posedge clk) disable iff (rst)
        limit_style > MSA_STYLE_HYST |-> beyond == 3'h0)
        else $error("reserved style produced a crossing");

    a_reserved_bit: assert property (@(posedge clk) disable iff (rst)
        reg_req.rd && reg_req.addr == MSA_OFS_LIMIT_SETUP |=> rdata[7] == 1'b0)
        else $error("reserved bit read as one");

    a_angle_off: assert property (@(posedge clk) disable iff (rst)
        angle_code == MSA_ANGLE_OFF && $stable(angle_code) |=> !angle_setup.en)
        else $error("angle left on with pair code zero");

endmodule // msa_limit_setup

// file: msa_conv_engine.sv
`timescale 1ns/1ps
module msa_conv_engine (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Handshake with the idle timer
    input  wire logic conversion_request,
    input  wire logic slow,
    output logic      conversion_done
);
    int cnt;
    // Slow answers hold the timer in its convert state longer, with cnt starting at 9 instead of 2
    always_ff @(posedge clk) begin
        conversion_done <= 1'b0;
        if (rst) begin
            cnt <= 0;
        end else if (conversion_request) begin
            cnt <= slow ? 9 : 2;
        end else if (cnt == 1) begin
            cnt             <= 0;
            conversion_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // msa_conv_engine

// file: msa_limit_setup_tb_top.sv
`timescale 1ns/1ps
module msa_limit_setup_tb_top;
    import msa_pkg::*;
    localparam int MS   = 4;
    localparam int BASE = 40;
    ////////////////////////////////////////////////////////////////////////////////
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    msa_reg_req_s     req = '0;
    logic [7:0]       rdata, v, cfg;
    logic [1:0]       power_state = 2'h0;
    logic [2:0]       limit_style = 3'h0;
    logic             done, creq, xy_d, z_d, lim_ev;
    logic [2:0]       axis_en;
    msa_seq_s         seq;
    msa_angle_s       ang;
    logic             sv = 1'b0;
    logic             ev_clr = 1'b0;
    logic             slow = 1'b0;
    logic [2:0][17:0] field = '0;
    logic [2:0][17:0] level;
    logic [7:0]       lc [3];
    logic [3:0]       a;
    logic [1:0]       k;
    int               error_cnt = 0;
    int               n_checks = 0;
    int               cyc = 0;
    int               n;
    int               idle [3] = '{1, 5, 10};
    msa_axis_e        sa [4] = '{MSA_AX_X, MSA_AX_Y, MSA_AX_Y, MSA_AX_X};
    msa_axis_e        sb [4] = '{MSA_AX_Y, MSA_AX_X, MSA_AX_Z, MSA_AX_Z};
    msa_axis_e        a1 [4] = '{MSA_AX_NONE, MSA_AX_X, MSA_AX_Y, MSA_AX_X};
    msa_axis_e        a2 [4] = '{MSA_AX_NONE, MSA_AX_Y, MSA_AX_Z, MSA_AX_Z};

    always #5 clk = ~clk;

    msa_limit_setup #(.MS_CYCLES(MS)) dut (
        .clk(clk), .rst(rst), .reg_req(req), .rdata(rdata), .power_state(power_state),
        .limit_style(limit_style), .conversion_done(done), .conversion_request(creq),
        .axis_enable(axis_en), .axis_sequence(seq), .angle_setup(ang),
        .xy_range_double(xy_d), .z_range_double(z_d), .sample_valid(sv),
        .field_sample(field), .limit_level(level), .limit_event_clear(ev_clr),
        .limit_event(lim_ev));
    msa_conv_engine partner (.clk(clk), .rst(rst), .conversion_request(creq), .slow(slow),
        .conversion_done(done));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Returns after the edge at which derived outputs follow the write
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge clk) req <= '0;
        @(posedge clk) #1;
    endtask

    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask

    task automatic sample(input logic [17:0] fx, input logic exp);
        @(posedge clk) begin
            sv    <= 1'b1;
            field <= {36'h0, fx};
        end
        @(posedge clk) sv <= 1'b0;
        @(posedge clk) #1;
        chk(lim_ev, exp);
    endtask

    task automatic clear_event;
        @(posedge clk) ev_clr <= 1'b1;
        @(posedge clk) ev_clr <= 1'b0;
        #1 chk(lim_ev, 1'b0);
    endtask

    function automatic logic [2:0] axis_exp(input logic [3:0] c);
        case (c)
            4'h8, 4'h9: return 3'b011;
            4'hA:       return 3'b110;
            4'hB:       return 3'b101;
            default:    return c[2:0];
        endcase
    endfunction

    // Level in 1/128 mT; symmetric style keeps only the magnitude bits
    function automatic logic [17:0] lvl(input logic [7:0] c, input logic sp, input logic sym);
        logic signed [17:0] m;
        m = sym ? 18'(c[6:0]) : 18'($signed(c));
        return 18'(m * BASE * (sp ? 2 : 1));
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop;
        end
    end

    initial begin
        void'($urandom(32'h28e2));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(i[3:0], v);
            chk(v, MSA_RESET_VALUE);
        end
        // Offset 7 is unmapped, so its writes must vanish
        for (int i = 0; i < 18; i++) begin
            a = 4'(2 + i % 6);
            v = 8'($urandom);
            v[7:4] = 4'(v[7:4] % 12);
            v[3:0] = 4'(v[3:0] % 13);
            wr(a, v);
            rd(a, cfg);
            chk(cfg, (a == 3) ? (v & MSA_LIMIT_SETUP_MASK) : ((a == 7) ? 8'h00 : v));
        end
        for (int c = 0; c < 12; c++) begin
            wr(MSA_OFS_AXIS_SETUP, {c[3:0], 4'h0});
            chk(axis_en, axis_exp(c[3:0]));
            if (c > 7) chk(seq, {2'h3, sa[c-8], sb[c-8], sa[c-8]});
            if (c == 7) chk(seq, {2'h3, MSA_AX_X, MSA_AX_Y, MSA_AX_Z});
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) limit_style <= {2'b00, i[0]};
            for (int x = 0; x < 3; x++) begin
                lc[x] = (i == 0) ? 8'h00 : 8'($urandom);
                wr(4'(MSA_OFS_X_LIMIT + x), lc[x]);
            end
            cfg = 8'($urandom) & MSA_LIMIT_SETUP_MASK;
            wr(MSA_OFS_LIMIT_SETUP, cfg);
            k = cfg[3:2];
            if (k == 0) chk(ang.en, 1'b0);
            else chk(ang, {1'b1, a1[k], a2[k], cfg[4] ? a2[k] : a1[k]});
            chk({xy_d, z_d}, cfg[1:0]);
            for (int x = 0; x < 3; x++) begin
                chk(level[x], lvl(lc[x], (x == 2) ? cfg[0] : cfg[1], i[0]));
            end
        end
        @(posedge clk) limit_style <= MSA_STYLE_SIGNED;
        wr(MSA_OFS_Y_LIMIT, 8'h00);
        wr(MSA_OFS_Z_LIMIT, 8'h00);
        wr(MSA_OFS_X_LIMIT, 8'h01);
        wr(MSA_OFS_LIMIT_SETUP, 8'h00);
        clear_event;
        sample(18'(0), 1'b0);
        sample(18'(BASE + 1), 1'b1);
        clear_event;
        wr(MSA_OFS_LIMIT_SETUP, 8'h20);
        sample(18'(BASE + 1), 1'b0);
        sample(18'(0), 1'b1);
        clear_event;
        wr(MSA_OFS_LIMIT_SETUP, 8'h40);
        for (int j = 0; j < 4; j++) begin
            sample(18'(0), 1'b0);
            sample(18'(BASE + 1), j == 3);
        end
        clear_event;
        @(posedge clk) limit_style <= 3'h2;
        wr(MSA_OFS_LIMIT_SETUP, 8'h20);
        sample(18'(BASE + 1), 1'b0);
        sample(18'(0), 1'b0);
        @(posedge clk) limit_style <= MSA_STYLE_SIGNED;
        wr(MSA_OFS_X_LIMIT, 8'h00);
        wr(MSA_OFS_LIMIT_SETUP, 8'h00);
        sample(18'(0), 1'b0);
        sample(18'(BASE + 1), 1'b0);
        for (int c = 0; c < 3; c++) begin
            wr(MSA_OFS_AXIS_SETUP, {4'h1, c[3:0]});
            @(posedge clk) begin
                power_state <= MSA_PWR_WAKE_SLEEP;
                slow        <= c[0];
            end
            n = 0;
            while (n < 300 && creq !== 1'b1) begin
                @(posedge clk) #1;
                n++;
            end
            chk(n, idle[c] * MS + 1);
            repeat (20) @(posedge clk);
            power_state <= 2'h0;
        end
        // Power state 2, not wake-sleep, must leave the idle timer silent
        @(posedge clk) power_state <= 2'h2;
        n = 0;
        repeat (60) begin
            @(posedge clk) #1;
            if (creq === 1'b1) n++;
        end
        chk(n, 0);
        report_and_stop;
    end
endmodule // msa_limit_setup_tb_top
